/* inc/lma_pkg.sv */
// Package for the local memory arbiter and backplane cycle sequencer.
// Assumes a 10 MHz module clock shared by all requesters.
package lma_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int MEM_CYCLE_NS = 400;
    localparam int MEM_CYCLE_CLKS = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] MEM_CYCLE_LAST = 3'(MEM_CYCLE_CLKS - 1);
    localparam int REFRESH_INTERVAL_NS = 15000;
    localparam int REFRESH_CLKS = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
    localparam logic [7:0] REFRESH_LAST = 8'(REFRESH_CLKS - 1);

    // ****************************************
    // Encodings
    // ****************************************
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_CPU = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] SRC_REF = 2'h3;

    localparam logic [1:0] SIZE_8 = 2'h0;
    localparam logic [1:0] SIZE_16 = 2'h1;
    localparam logic [1:0] SIZE_32 = 2'h2;

    localparam logic [2:0] CYC_NONE = 3'h0;
    localparam logic [2:0] CYC_BYTE_WRITE = 3'h1;
    localparam logic [2:0] CYC_WORD_READ = 3'h2;
    localparam logic [2:0] CYC_WORD_WRITE = 3'h3;
    localparam logic [2:0] CYC_BLOCK_READ = 3'h4;
    localparam logic [2:0] CYC_BLOCK_WRITE = 3'h5;

    localparam int ADDR_W = 22;

    typedef enum logic [2:0] {
        LMA_BUS_IDLE,
        LMA_BUS_REQ,
        LMA_BUS_OWN,
        LMA_BUS_CYC,
        LMA_BUS_WAIT
    } lma_bus_state_t;
endpackage

/* rtl/lma_arbiter.sv */
// Local memory arbiter and backplane bus cycle sequencer.
// Assumes all inputs except the backplane grant/reply come from logic on clock.
// Functional notes
// RULE1 - Memory path and backplane ownership arbitrated separately
// RULE2 - CPU cycles continue until map translation done
// RULE3 - Idle memory decodes CPU address, else switches
// RULE4 - Idle grant order: CPU, external, refresh
// RULE5 - Completing grant order: external, refresh, CPU
// RULE6 - Every memory cycle lasts 400 ns
// RULE7 - CPU owns backplane before locked/map/bus access
// RULE8 - Arbiter module: CPU owns bus unless DMA granted
// RULE9 - Auxiliary module gains bus only via DMA grant
// RULE10 - Access size selects backplane cycle type
// RULE11 - Locked pair uses read then write cycles
// RULE12 - Non-block memory: two word cycles replace block
// RULE13 - Keep bus ownership across substituted word cycles
// RULE14 - Byte read uses word read, bit0 byte address
// RULE15 - Internal register accesses skip memory system
// RULE16 - Refresh requested periodically, held until done
`timescale 1ns/1ps
module lma_arbiter
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic cpu_mem_req,
    input wire logic cpu_ipr_access,
    input wire logic [lma_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic ext_mem_req,
    input wire logic map_done,
    input wire logic [lma_pkg::ADDR_W-1:0] map_addr,
    input wire logic [lma_pkg::ADDR_W-1:0] refresh_addr,
    input wire logic is_arbiter,
    input wire logic ext_dma_granted,
    input wire logic bus_dma_grant_in,
    input wire logic cpu_bus_req,
    input wire logic cpu_bus_write,
    input wire logic [1:0] cpu_bus_size,
    input wire logic cpu_bus_lock,
    input wire logic target_block_mode,
    input wire logic bus_cycle_done_in,
    output logic [1:0] mem_grant_r,
    output logic [lma_pkg::ADDR_W-1:0] mem_addr_r,
    output logic mem_busy_r,
    output logic refresh_req_r,
    output logic bus_own_r,
    output logic dma_req_r,
    output logic [2:0] bus_cycle_r,
    output logic bus_cycle_start_r,
    output logic bus_addr0_r,
    output logic cpu_bus_done_r
);
    // ****************************************
    // Input synchronisers for backplane pins
    // ****************************************
    logic grant_s1_r;
    logic grant_s2_r;
    logic done_s1_r;
    logic done_s2_r;

    // Two flops on asynchronous backplane inputs
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            grant_s1_r <= 1'b0;
            grant_s2_r <= 1'b0;
            done_s1_r <= 1'b0;
            done_s2_r <= 1'b0;
        end
        else
        begin
            grant_s1_r <= bus_dma_grant_in;
            grant_s2_r <= grant_s1_r;
            done_s1_r <= bus_cycle_done_in;
            done_s2_r <= done_s1_r;
        end
    end

    // ****************************************
    // Refresh request generator
    // ****************************************
    logic [7:0] ref_cnt_r;
    logic [2:0] cyc_cnt_r;
    logic mem_last;

    assign mem_last = mem_busy_r && (cyc_cnt_r == lma_pkg::MEM_CYCLE_LAST);

    // Periodic request held until its refresh cycle ends
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            ref_cnt_r <= 8'h00;
            refresh_req_r <= 1'b0;
        end
        else
        begin
            ref_cnt_r <= (ref_cnt_r == lma_pkg::REFRESH_LAST) ? 8'h00 : ref_cnt_r + 8'h01;
            if (ref_cnt_r == lma_pkg::REFRESH_LAST)
                refresh_req_r <= 1'b1; // RULE16
            else if (mem_last && mem_grant_r == lma_pkg::SRC_REF)
                refresh_req_r <= 1'b0; // RULE16
        end
    end

    // ****************************************
    // Local memory arbitration
    // ****************************************
    logic cpu_want;
    logic ext_want;
    logic [1:0] pick_idle;
    logic [1:0] pick_done;
    logic [1:0] pick;

    // Internal register accesses never reach memory; map must finish first
    assign cpu_want = cpu_mem_req && !cpu_ipr_access; // RULE15
    assign ext_want = ext_mem_req && map_done; // RULE2

    // Fixed priority between cycles
    always_comb
    begin
        if (cpu_want)
            pick_idle = lma_pkg::SRC_CPU; // RULE4
        else if (ext_want)
            pick_idle = lma_pkg::SRC_EXT;
        else if (refresh_req_r)
            pick_idle = lma_pkg::SRC_REF;
        else
            pick_idle = lma_pkg::SRC_NONE;
    end

    // Fixed priority while finishing a cycle
    always_comb
    begin
        if (ext_want)
            pick_done = lma_pkg::SRC_EXT; // RULE5
        else if (refresh_req_r && mem_grant_r != lma_pkg::SRC_REF)
            pick_done = lma_pkg::SRC_REF;
        else if (cpu_want && mem_grant_r != lma_pkg::SRC_CPU)
            pick_done = lma_pkg::SRC_CPU;
        else
            pick_done = lma_pkg::SRC_NONE;
    end

    assign pick = mem_busy_r ? pick_done : pick_idle;

    // Cycle timer and grant holder, one grant per 400 ns cycle
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            mem_busy_r <= 1'b0;
            cyc_cnt_r <= 3'h0;
            mem_grant_r <= lma_pkg::SRC_NONE;
        end
        else if (!mem_busy_r || mem_last)
        begin
            mem_busy_r <= (pick != lma_pkg::SRC_NONE); // RULE6
            cyc_cnt_r <= 3'h0;
            mem_grant_r <= pick;
        end
        else
        begin
            cyc_cnt_r <= cyc_cnt_r + 3'h1; // RULE6
        end
    end

    // Idle memory serves the processor first
    a_idle_priority: assert property (@(posedge clock) disable iff (!resetn) // RULE4
        (!mem_busy_r && cpu_want) |=> (mem_grant_r == lma_pkg::SRC_CPU))
        else $error("idle grant skipped the processor");

    // A finishing cycle hands over to the external master first
    a_done_priority: assert property (@(posedge clock) disable iff (!resetn) // RULE5
        (mem_last && ext_want) |=> (mem_grant_r == lma_pkg::SRC_EXT))
        else $error("finishing grant skipped the external master");

    // Each granted cycle stays busy for four clocks
    a_cycle_length: assert property (@(posedge clock) disable iff (!resetn) // RULE6
        (mem_busy_r && cyc_cnt_r == 3'h0) |-> mem_busy_r [*4])
        else $error("memory cycle ended early");

    // Internal register accesses never start a memory cycle
    a_ipr_no_memory: assert property (@(posedge clock) disable iff (!resetn) // RULE15
        (!mem_busy_r && cpu_mem_req && cpu_ipr_access && !ext_want && !refresh_req_r)
        |=> !mem_busy_r)
        else $error("register access occupied memory");

    // Address source: CPU lines while idle or for CPU grants, else refresh or map
    always_ff @(posedge clock)
    begin
        if (!resetn)
            mem_addr_r <= '0;
        else if (!mem_busy_r || mem_last)
        begin
            case (pick)
                lma_pkg::SRC_EXT: mem_addr_r <= map_addr; // RULE3
                lma_pkg::SRC_REF: mem_addr_r <= refresh_addr; // RULE3
                lma_pkg::SRC_CPU: mem_addr_r <= cpu_addr;
                default: mem_addr_r <= cpu_addr; // RULE3
            endcase
        end
    end

    // External grants take the translated map address
    a_ext_address: assert property (@(posedge clock) disable iff (!resetn) // RULE3
        ((!mem_busy_r || mem_last) && pick == lma_pkg::SRC_EXT) |=> (mem_addr_r == $past(map_addr)))
        else $error("external cycle missed map address");

    // ****************************************
    // Backplane ownership and cycle sequencing
    // ****************************************
    lma_pkg::lma_bus_state_t bus_state_r;
    logic second_r;
    logic lock_hold_r;
    logic in_seq;
    logic own_ok;
    logic seq_end;

    // Backplane cycle type from access size and direction
    function automatic logic [2:0] lma_cycle_kind(input logic write, input logic [1:0] size,
        input logic block);
        logic [2:0] kind;
        kind = lma_pkg::CYC_NONE;
        case (size)
            lma_pkg::SIZE_8: kind = write ? lma_pkg::CYC_BYTE_WRITE : lma_pkg::CYC_WORD_READ;
            lma_pkg::SIZE_16: kind = write ? lma_pkg::CYC_WORD_WRITE : lma_pkg::CYC_WORD_READ;
            lma_pkg::SIZE_32:
            begin
                if (block)
                    kind = write ? lma_pkg::CYC_BLOCK_WRITE : lma_pkg::CYC_BLOCK_READ;
                else
                    kind = write ? lma_pkg::CYC_WORD_WRITE : lma_pkg::CYC_WORD_READ; // RULE12
            end
            default: kind = lma_pkg::CYC_NONE;
        endcase
        return kind;
    endfunction

    // Ownership is kept through cycles and a pending locked pair
    assign in_seq = (bus_state_r == lma_pkg::LMA_BUS_CYC) ||
        (bus_state_r == lma_pkg::LMA_BUS_WAIT) || lock_hold_r; // RULE13
    // Backplane access decided apart from the memory grant
    assign own_ok = is_arbiter ? !ext_dma_granted : (grant_s2_r && dma_req_r); // RULE1
    // Last reply of a sequence
    assign seq_end = (bus_state_r == lma_pkg::LMA_BUS_WAIT) && done_s2_r && !second_r;

    // Ownership flag and DMA request of an auxiliary module
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            bus_own_r <= 1'b0;
            dma_req_r <= 1'b0;
        end
        else
        begin
            bus_own_r <= in_seq || own_ok; // RULE8
            dma_req_r <= !is_arbiter && (cpu_bus_req || bus_state_r != lma_pkg::LMA_BUS_IDLE ||
                lock_hold_r); // RULE9
        end
    end

    // Cycle sequencer: request, own, issue, wait for reply
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            bus_state_r <= lma_pkg::LMA_BUS_IDLE;
            bus_cycle_r <= lma_pkg::CYC_NONE;
            bus_cycle_start_r <= 1'b0;
            bus_addr0_r <= 1'b0;
            second_r <= 1'b0;
        end
        else
        begin
            bus_cycle_start_r <= 1'b0;
            case (bus_state_r)
                lma_pkg::LMA_BUS_IDLE:
                begin
                    if (cpu_bus_req)
                        bus_state_r <= lma_pkg::LMA_BUS_REQ;
                end
                lma_pkg::LMA_BUS_REQ:
                begin
                    if (own_ok) // RULE7
                    begin
                        bus_state_r <= lma_pkg::LMA_BUS_CYC;
                        bus_cycle_start_r <= 1'b1;
                        bus_cycle_r <= lma_cycle_kind(cpu_bus_write, cpu_bus_size,
                            target_block_mode); // RULE10
                        second_r <= (cpu_bus_size == lma_pkg::SIZE_32) && !target_block_mode;
                        bus_addr0_r <= (cpu_bus_size == lma_pkg::SIZE_8) ? cpu_addr[0] : 1'b0; // RULE14
                    end
                end
                lma_pkg::LMA_BUS_CYC: bus_state_r <= lma_pkg::LMA_BUS_WAIT;
                lma_pkg::LMA_BUS_WAIT:
                begin
                    if (done_s2_r && second_r)
                    begin
                        bus_state_r <= lma_pkg::LMA_BUS_CYC; // RULE12
                        bus_cycle_start_r <= 1'b1;
                        second_r <= 1'b0;
                    end
                    else if (done_s2_r)
                        bus_state_r <= lma_pkg::LMA_BUS_OWN;
                end
                lma_pkg::LMA_BUS_OWN:
                begin
                    if (!cpu_bus_req)
                        bus_state_r <= lma_pkg::LMA_BUS_IDLE;
                end
                default: bus_state_r <= lma_pkg::LMA_BUS_IDLE;
            endcase
        end
    end

    // Done stands until the processor drops its request
    always_ff @(posedge clock)
    begin
        if (!resetn)
            cpu_bus_done_r <= 1'b0;
        else
            cpu_bus_done_r <= seq_end || (bus_state_r == lma_pkg::LMA_BUS_OWN && cpu_bus_req);
    end

    // Locked read keeps the bus until the unlocking write
    always_ff @(posedge clock)
    begin
        if (!resetn)
            lock_hold_r <= 1'b0;
        else if (seq_end && cpu_bus_write)
            lock_hold_r <= 1'b0; // RULE11
        else if (seq_end && cpu_bus_lock)
            lock_hold_r <= 1'b1; // RULE11
    end

    // No backplane cycle without ownership
    a_cycle_owned: assert property (@(posedge clock) disable iff (!resetn) // RULE7
        bus_cycle_start_r |-> bus_own_r)
        else $error("backplane cycle without ownership");

    // Ownership held between substituted word cycles
    a_sub_keep_own: assert property (@(posedge clock) disable iff (!resetn) // RULE13
        (bus_state_r == lma_pkg::LMA_BUS_WAIT && second_r) |=> bus_own_r)
        else $error("ownership dropped between word cycles");

    // Arbiter module owns the bus unless DMA is granted
    a_arbiter_owns: assert property (@(posedge clock) disable iff (!resetn) // RULE8
        (is_arbiter && !ext_dma_granted) |=> bus_own_r)
        else $error("arbiter module lost the bus");
endmodule

/* testbench/lma_bus_model.sv */
// Backplane model: replies to cycles and DMA requests.
// Assumes the arbiter clock; replies come late by fixed counts.
`timescale 1ns/1ps
module lma_bus_model
(
    input wire logic clock,
    input wire logic cycle_start,
    input wire logic dma_req,
    output logic cycle_done,
    output logic dma_grant
);
    logic [1:0] dly_r = 2'h0;
    // Reply three clocks after a start; grant DMA one clock late
    always_ff @(posedge clock)
    begin
        dly_r <= {dly_r[0], cycle_start};
        cycle_done <= dly_r[1];
        dma_grant <= dma_req;
    end
endmodule

/* testbench/lma_arbiter_bench.sv */
// Bench for the local memory arbiter and bus cycle sequencer.
// Assumes lma_bus_model as backplane.
`timescale 1ns/1ps
module lma_arbiter_bench;
    logic clock = 0, resetn = 0, cpu_mem_req = 0, cpu_ipr_access = 0, ext_mem_req = 0;
    logic map_done = 1, is_arbiter = 1, ext_dma_granted = 0, cpu_bus_req = 0;
    logic cpu_bus_write = 0, cpu_bus_lock = 0, target_block_mode = 1;
    logic bus_dma_grant_in, bus_cycle_done_in, mem_busy_r, refresh_req_r, bus_own_r;
    logic dma_req_r, bus_cycle_start_r, bus_addr0_r, cpu_bus_done_r;
    logic [1:0] cpu_bus_size = 0, mem_grant_r;
    logic [2:0] bus_cycle_r;
    logic [lma_pkg::ADDR_W-1:0] cpu_addr = 22'h1, map_addr = 22'h2AAAA4, refresh_addr = 22'h3F;
    logic [lma_pkg::ADDR_W-1:0] mem_addr_r;
    int err_total = 0, checked = 0;
    lma_arbiter i_dut (.clock, .resetn, .cpu_mem_req, .cpu_ipr_access, .cpu_addr, .ext_mem_req,
        .map_done, .map_addr, .refresh_addr, .is_arbiter, .ext_dma_granted, .bus_dma_grant_in,
        .cpu_bus_req, .cpu_bus_write, .cpu_bus_size, .cpu_bus_lock, .target_block_mode,
        .bus_cycle_done_in, .mem_grant_r, .mem_addr_r, .mem_busy_r, .refresh_req_r, .bus_own_r,
        .dma_req_r, .bus_cycle_r, .bus_cycle_start_r, .bus_addr0_r, .cpu_bus_done_r);
    lma_bus_model i_bus (.clock, .cycle_start(bus_cycle_start_r), .dma_req(dma_req_r),
        .cycle_done(bus_cycle_done_in), .dma_grant(bus_dma_grant_in));
    // Clock of 100 ns
    initial
    begin
        forever #50 clock = ~clock;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic want_grant(logic [1:0] src);
        for (int k = 0; k < 200 && mem_grant_r !== src; k++) tick(1);
        chk(mem_grant_r, src);
    endtask
    task automatic bus_op(logic w, logic [1:0] sz, logic blk, logic [2:0] exp, int n);
        int k = 0;
        {cpu_bus_write, cpu_bus_size, target_block_mode, cpu_bus_req} = {w, sz, blk, 1'b1};
        for (int t = 0; t < 60 && cpu_bus_done_r !== 1'b1; t++)
        begin
            tick(1);
            if (bus_cycle_start_r === 1'b1)
            begin
                k++;
                chk(bus_cycle_r, exp);
                chk(bus_own_r, 1);
                if (sz == lma_pkg::SIZE_8) chk(bus_addr0_r, cpu_addr[0]);
            end
        end
        chk(k, n);
        cpu_bus_req = 0;
        tick(2);
    endtask
    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clock);
        err_total++;
        stop_test();
    end
    initial
    begin
        int n;
        tick(5);
        resetn = 1;
        tick(2);
        chk(bus_own_r, 1);
        ext_dma_granted = 1;
        tick(3);
        chk(bus_own_r, 0);
        ext_dma_granted = 0;
        tick(3);
        $display("ownership test done");
        cpu_mem_req = 1;
        want_grant(lma_pkg::SRC_CPU);
        chk(mem_addr_r, cpu_addr);
        cpu_mem_req = 0;
        for (n = 0; mem_busy_r === 1'b1 && n < 9; n++) tick(1);
        chk(n, lma_pkg::MEM_CYCLE_CLKS);
        {cpu_mem_req, ext_mem_req} = 2'h3;
        want_grant(lma_pkg::SRC_CPU);
        want_grant(lma_pkg::SRC_EXT);
        chk(mem_addr_r, map_addr);
        {cpu_mem_req, ext_mem_req} = 2'h0;
        want_grant(lma_pkg::SRC_REF);
        chk(mem_addr_r, refresh_addr);
        chk(refresh_req_r, 1);
        {cpu_mem_req, cpu_ipr_access} = 2'h3;
        for (n = 0; n < 8; n++)
        begin
            tick(1);
            chk(mem_grant_r == lma_pkg::SRC_CPU, 0);
        end
        {cpu_mem_req, cpu_ipr_access} = 2'h0;
        $display("memory test done");
        bus_op(1, lma_pkg::SIZE_8, 1, lma_pkg::CYC_BYTE_WRITE, 1);
        bus_op(0, lma_pkg::SIZE_8, 1, lma_pkg::CYC_WORD_READ, 1);
        bus_op(1, lma_pkg::SIZE_16, 1, lma_pkg::CYC_WORD_WRITE, 1);
        bus_op(0, lma_pkg::SIZE_32, 1, lma_pkg::CYC_BLOCK_READ, 1);
        bus_op(1, lma_pkg::SIZE_32, 1, lma_pkg::CYC_BLOCK_WRITE, 1);
        bus_op(1, lma_pkg::SIZE_32, 0, lma_pkg::CYC_WORD_WRITE, 2);
        cpu_bus_lock = 1;
        bus_op(0, lma_pkg::SIZE_16, 1, lma_pkg::CYC_WORD_READ, 1);
        bus_op(0, lma_pkg::SIZE_32, 0, lma_pkg::CYC_WORD_READ, 2);
        cpu_bus_lock = 0;
        bus_op(1, lma_pkg::SIZE_16, 1, lma_pkg::CYC_WORD_WRITE, 1);
        $display("bus cycle test done");
        is_arbiter = 0;
        tick(3);
        chk(bus_own_r, 0);
        bus_op(1, lma_pkg::SIZE_16, 1, lma_pkg::CYC_WORD_WRITE, 1);
        tick(3);
        chk(bus_own_r, 0);
        chk(dma_req_r, 0);
        $display("auxiliary test done");
        stop_test();
    end
endmodule
